// *** hw/bsc_ctrl.sv ***
// Boost converter control: sync decode, spread spectrum, frequency range and switch current limit
`timescale 1ns/1ps
module bsc_ctrl #(
  parameter int unsigned CL_HOLD_CYC  = bsc_pkg::CL_HOLD_CYC,
  parameter int unsigned SYNC_WIN_CYC = bsc_pkg::SYNC_WIN_CYC,
  parameter int unsigned TRI_STEP_CYC = bsc_pkg::TRI_STEP_CYC
)
(
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_io_supply_enable_pin,  // Pin, high enables
  input  wire logic                        i_sync_pin,              // Pin, level or clock
  input  wire logic [bsc_pkg::R10_W-1:0]   i_freq_program_resistor, // Resistor in 0.1 kohm
  input  wire logic [bsc_pkg::ILIM_W-1:0]  i_switch_current_ma,     // Sensed switch current
  input  wire logic                        i_loop_trip,             // Peak-current loop wants off
  output logic                             o_switch_gate,           // Drives the power_switch_node FET
  output logic                             o_enabled,
  output logic                             o_ext_sync,
  output logic                             o_dither_on,
  output logic [1:0]                       o_freq_range,
  output logic [bsc_pkg::TIME_W-1:0]       o_min_off_cyc,
  output logic [bsc_pkg::TIME_W-1:0]       o_blank_cyc,
  output logic [bsc_pkg::ILIM_W-1:0]       o_ilimit_ma,
  output logic                             o_ilimit_raised,
  output logic                             o_cl_trip
);
  localparam int WIN_W  = $clog2(SYNC_WIN_CYC + 1);
  localparam int HOLD_W = $clog2(CL_HOLD_CYC + 1);
  localparam int CNT_W  = 10;

  logic                         run;
  logic                         sync_lvl;
  logic                         sync_prev;
  logic                         sync_rise;
  logic                         tri_tick;
  logic [bsc_pkg::R10_W-1:0]    r10;
  logic [1:0]                   next_range;
  logic [bsc_pkg::TIME_W-1:0]   next_min_off;
  logic [bsc_pkg::TIME_W-1:0]   next_blank;
  logic [WIN_W-1:0]             win_cnt;
  logic [WIN_W-1:0]             next_win_cnt;
  logic                         next_ext;
  logic                         next_dither;
  logic [bsc_pkg::DITH_W-1:0]   tri_u;
  logic [bsc_pkg::DITH_W-1:0]   next_tri_u;
  logic [bsc_pkg::DITH_W-1:0]   tri_eff;
  logic                         tri_up;
  logic                         next_tri_up;
  logic [bsc_pkg::PER_W-1:0]    per_q8;
  logic [bsc_pkg::PER_W-1:0]    per_dith;
  logic [bsc_pkg::PER_W-1:0]    phase;
  logic [bsc_pkg::PER_W-1:0]    next_phase;
  logic                         acc_tick;
  logic                         next_acc_tick;
  logic                         cyc_start;
  bsc_pkg::bsc_sw_t             sw_state;
  bsc_pkg::bsc_sw_t             next_sw_state;
  logic [CNT_W-1:0]             sw_cnt;
  logic [CNT_W-1:0]             next_sw_cnt;
  logic                         blanked;
  logic                         lim_hit;
  logic                         next_cl_trip;
  bsc_pkg::bsc_cl_t             cl_state;
  bsc_pkg::bsc_cl_t             next_cl_state;
  logic [HOLD_W-1:0]            hold_cnt;
  logic [HOLD_W-1:0]            next_hold_cnt;
  logic [CNT_W-1:0]             off_len;

  // Pin synchronisers
  bsc_sync3 u_en_sync (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_pin(i_io_supply_enable_pin), .o_level(run));
  bsc_sync3 u_sy_sync (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_pin(i_sync_pin), .o_level(sync_lvl));
  bsc_tick #(.DIV(TRI_STEP_CYC)) u_tri_tick
  (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_run     (run),
    .o_pulse   (tri_tick)
  );

  assign o_enabled     = run;
  assign sync_rise     = sync_lvl && !sync_prev;
  // Centre point while dithering is off, so the period is exact the same cycle dither drops
  assign tri_eff       = o_dither_on ? tri_u : bsc_pkg::DITH_W'(bsc_pkg::DITH_HALF);
  assign o_switch_gate = (sw_state == bsc_pkg::SW_ON);

  // Frequency range and its converter parameters
  always_comb
  begin
    if (r10 > bsc_pkg::R10_W'(bsc_pkg::R10_AT_B1))
    begin
      next_range   = 2'h0;
      next_min_off = bsc_pkg::MIN_OFF_R1_CYC;
      next_blank   = bsc_pkg::BLANK_LO_CYC;
    end
    else if (r10 > bsc_pkg::R10_W'(bsc_pkg::R10_AT_B2))
    begin
      next_range   = 2'h1;
      next_min_off = bsc_pkg::MIN_OFF_R2_CYC;
      next_blank   = bsc_pkg::BLANK_LO_CYC;
    end
    else if (r10 > bsc_pkg::R10_W'(bsc_pkg::R10_AT_B3))
    begin
      next_range   = 2'h2;
      next_min_off = bsc_pkg::MIN_OFF_R3_CYC;
      next_blank   = bsc_pkg::BLANK_LO_CYC;
    end
    else
    begin
      next_range   = 2'h3;
      next_min_off = bsc_pkg::MIN_OFF_R4_CYC;
      next_blank   = bsc_pkg::BLANK_HI_CYC;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      r10           <= '0;
      o_freq_range  <= 2'h3;
      o_min_off_cyc <= bsc_pkg::MIN_OFF_R4_CYC;
      o_blank_cyc   <= bsc_pkg::BLANK_HI_CYC;
    end
    else
    begin
      r10           <= i_freq_program_resistor;
      o_freq_range  <= next_range;
      o_min_off_cyc <= next_min_off;
      o_blank_cyc   <= next_blank;
    end
  end

  // Sync decode: clock while rising edges arrive inside the window, else static level
  always_comb
  begin
    next_win_cnt = win_cnt;
    next_ext     = o_ext_sync;
    if (!run)
    begin
      next_win_cnt = WIN_W'(SYNC_WIN_CYC);
      next_ext     = 1'b0;
    end
    else if (sync_rise)
    begin
      next_ext     = (win_cnt < WIN_W'(SYNC_WIN_CYC));
      next_win_cnt = '0;
    end
    else if (win_cnt < WIN_W'(SYNC_WIN_CYC))
      next_win_cnt = win_cnt + 1'b1;
    else
      next_ext     = 1'b0;
    next_dither = run && !next_ext && sync_lvl;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      sync_prev   <= 1'b0;
      win_cnt     <= WIN_W'(SYNC_WIN_CYC);
      o_ext_sync  <= 1'b0;
      o_dither_on <= 1'b0;
    end
    else
    begin
      sync_prev   <= sync_lvl;
      win_cnt     <= next_win_cnt;
      o_ext_sync  <= next_ext;
      o_dither_on <= next_dither;
    end
  end

  // Triangle modulation stepping up and down across the dither span
  always_comb
  begin
    next_tri_u  = tri_u;
    next_tri_up = tri_up;
    if (!o_dither_on)
    begin
      next_tri_u  = bsc_pkg::DITH_W'(bsc_pkg::DITH_HALF);
      next_tri_up = 1'b1;
    end
    else if (tri_tick)
    begin
      if (tri_up && tri_u == bsc_pkg::DITH_W'(bsc_pkg::DITH_SPAN))
      begin
        next_tri_up = 1'b0;
        next_tri_u  = tri_u - 1'b1;
      end
      else if (!tri_up && tri_u == '0)
      begin
        next_tri_up = 1'b1;
        next_tri_u  = tri_u + 1'b1;
      end
      else
        next_tri_u = tri_up ? tri_u + 1'b1 : tri_u - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      tri_u  <= bsc_pkg::DITH_W'(bsc_pkg::DITH_HALF);
      tri_up <= 1'b1;
    end
    else
    begin
      tri_u  <= next_tri_u;
      tri_up <= next_tri_up;
    end
  end

  // Period from the resistor, then offset by the triangle; phase accumulator, held at zero while disabled or in external sync
  always_comb
  begin
    // Products are formed at 32 bits so nothing overflows before the shift
    per_q8   = bsc_pkg::PER_W'(((32'(r10) + 32'(bsc_pkg::FREQ_PROGRAM_PIN_OFS_R10)) * 32'(bsc_pkg::PER_MULT))
                               >> bsc_pkg::PER_SHIFT);
    per_dith = per_q8 - bsc_pkg::PER_W'((32'(per_q8) * 32'(bsc_pkg::DITH_HALF)) >> bsc_pkg::DITH_SHIFT)
                      + bsc_pkg::PER_W'((32'(per_q8) * 32'(tri_eff)) >> bsc_pkg::DITH_SHIFT);
    next_phase    = phase + bsc_pkg::PER_W'(bsc_pkg::PHASE_STEP);
    next_acc_tick = 1'b0;
    if (!run || o_ext_sync)
      next_phase = '0;
    else if (next_phase >= per_dith)
    begin
      next_phase    = next_phase - per_dith;
      next_acc_tick = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      phase    <= '0;
      acc_tick <= 1'b0;
    end
    else
    begin
      phase    <= next_phase;
      acc_tick <= next_acc_tick;
    end
  end

  // Switch gate: on at cycle start, off on limit, loop trip or next start; then minimum off time
  assign cyc_start = o_ext_sync ? sync_rise : acc_tick;
  assign blanked   = (sw_cnt >= CNT_W'(o_blank_cyc));
  assign lim_hit   = (sw_state == bsc_pkg::SW_ON) && blanked && (i_switch_current_ma >= o_ilimit_ma);

  always_comb
  begin
    next_sw_state = sw_state;
    next_sw_cnt   = (sw_cnt == '1) ? sw_cnt : sw_cnt + 1'b1;
    next_cl_trip  = 1'b0;
    case (sw_state)
      bsc_pkg::SW_REST:
        if (next_sw_cnt >= CNT_W'(o_min_off_cyc))
          next_sw_state = bsc_pkg::SW_READY;
      bsc_pkg::SW_READY:
        if (cyc_start)
        begin
          next_sw_state = bsc_pkg::SW_ON;
          next_sw_cnt   = '0;
        end
      bsc_pkg::SW_ON:
        if (lim_hit || (blanked && i_loop_trip) || cyc_start)
        begin
          next_sw_state = bsc_pkg::SW_REST;
          next_sw_cnt   = '0;
          next_cl_trip  = lim_hit;
        end
      default:
        next_sw_state = bsc_pkg::SW_REST;
    endcase
    if (!run)
    begin
      next_sw_state = bsc_pkg::SW_REST;
      next_sw_cnt   = '0;
      next_cl_trip  = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      sw_state  <= bsc_pkg::SW_REST;
      sw_cnt    <= '0;
      o_cl_trip <= 1'b0;
    end
    else
    begin
      sw_state  <= next_sw_state;
      sw_cnt    <= next_sw_cnt;
      o_cl_trip <= next_cl_trip;
    end
  end

  // Current limit: first hit raises the limit, then a normal period before it may rise again
  always_comb
  begin
    next_cl_state = cl_state;
    next_hold_cnt = hold_cnt + 1'b1;
    case (cl_state)
      bsc_pkg::CL_NORMAL:
      begin
        next_hold_cnt = '0;
        if (lim_hit)
          next_cl_state = bsc_pkg::CL_RAISED;
      end
      bsc_pkg::CL_RAISED:
        if (hold_cnt == HOLD_W'(CL_HOLD_CYC - 1))
        begin
          next_cl_state = bsc_pkg::CL_COOL;
          next_hold_cnt = '0;
        end
      bsc_pkg::CL_COOL:
        if (hold_cnt == HOLD_W'(CL_HOLD_CYC - 1))
        begin
          next_cl_state = bsc_pkg::CL_NORMAL;
          next_hold_cnt = '0;
        end
      default:
        next_cl_state = bsc_pkg::CL_NORMAL;
    endcase
    if (!run)
    begin
      next_cl_state = bsc_pkg::CL_NORMAL;
      next_hold_cnt = '0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      cl_state        <= bsc_pkg::CL_NORMAL;
      hold_cnt        <= '0;
      o_ilimit_ma     <= bsc_pkg::ILIM_NORM_MA;
      o_ilimit_raised <= 1'b0;
    end
    else
    begin
      cl_state        <= next_cl_state;
      hold_cnt        <= next_hold_cnt;
      o_ilimit_ma     <= (next_cl_state == bsc_pkg::CL_RAISED) ? bsc_pkg::ILIM_RAISE_MA : bsc_pkg::ILIM_NORM_MA;
      o_ilimit_raised <= (next_cl_state == bsc_pkg::CL_RAISED);
    end
  end

  // Helper for assertions: cycles the gate has been low
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      off_len <= '0;
    else
      off_len <= o_switch_gate ? '0 : ((off_len == '1) ? off_len : off_len + 1'b1);
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  a_low_no_dither:  assert property ($past(!sync_lvl) |-> !o_dither_on) else $error("dither on at low sync");
  a_high_dither:    assert property ($past(run && sync_lvl) && !o_ext_sync |-> o_dither_on)
                      else $error("dither off at high sync");
  a_dither_bound:   assert property (tri_u <= bsc_pkg::DITH_W'(bsc_pkg::DITH_SPAN) && (o_dither_on || per_dith == per_q8))
                      else $error("dither outside span");
  a_ext_no_dither:  assert property (o_ext_sync |-> !o_dither_on) else $error("dither in external sync");
  a_ext_restart:    assert property (run && o_ext_sync && sync_rise && sw_state == bsc_pkg::SW_READY |=> o_switch_gate)
                      else $error("external edge did not start cycle");
  a_range_map:      assert property (run && $past(r10 > bsc_pkg::R10_W'(bsc_pkg::R10_AT_B1)) |-> o_freq_range == 2'h0
                      && o_min_off_cyc == bsc_pkg::MIN_OFF_R1_CYC) else $error("low range not selected");
  a_off_time:       assert property ($rose(o_switch_gate) && $stable(o_min_off_cyc) |-> off_len >= CNT_W'(o_min_off_cyc))
                      else $error("minimum off time violated");
  a_limit_cut:      assert property (lim_hit |=> !o_switch_gate ##1 !o_switch_gate) else $error("switch not cut");
  a_limit_raise:    assert property (cl_state == bsc_pkg::CL_NORMAL && lim_hit && run |=> o_ilimit_ma == bsc_pkg::ILIM_RAISE_MA)
                      else $error("limit not raised");
  a_cool_normal:    assert property (cl_state == bsc_pkg::CL_COOL |-> o_ilimit_ma == bsc_pkg::ILIM_NORM_MA && !o_ilimit_raised
                      && hold_cnt < HOLD_W'(CL_HOLD_CYC)) else $error("cool period limit wrong");
  a_disabled:       assert property (!run |=> !o_switch_gate && !o_dither_on && !o_ext_sync)
                      else $error("active while disabled");
  a_sync_detect:    assert property (run && sync_rise && win_cnt < WIN_W'(SYNC_WIN_CYC) |=> o_ext_sync)
                      else $error("external clock not detected");

  c_ext_mode:   cover property ($rose(o_ext_sync));
  c_dither:     cover property ($rose(o_dither_on));
  c_raised:     cover property ($rose(o_ilimit_raised));
  c_cool:       cover property (cl_state == bsc_pkg::CL_COOL && lim_hit);
endmodule : bsc_ctrl

// *** hw/bsc_pkg.sv ***
// Constants and types shared by the boost sync, spread and current-limit control
package bsc_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_PER_MS    = 1000000 / CLK_PERIOD_NS;

  // Frequency setting: resistor value arrives in 0.1 kohm units
  localparam int R10_W         = 12;
  localparam int FREQ_PROGRAM_PIN_OFS_R10  = 64;                       // 6.4 kohm offset
  localparam int FREQ_PROGRAM_PIN_NUM_KHZ  = 67600;                    // Numerator in kHz * kohm
  localparam int FREQ_PROGRAM_PIN_NUM_R10  = FREQ_PROGRAM_PIN_NUM_KHZ * 10;
  // Period in 1/65536 cycles per 0.1 kohm, then shifted to 1/256 cycle units
  localparam int PER_MULT      = int'((64'd65536 * 64'd1000000) / (64'(FREQ_PROGRAM_PIN_NUM_R10) * 64'(CLK_PERIOD_NS)));
  localparam int PER_SHIFT     = 8;
  localparam int PER_W         = 20;
  localparam int PHASE_STEP    = 256;                      // One cycle in 1/256 units

  // Range boundaries in kHz and as resistor values
  localparam int RANGE_B1_KHZ  = 480;
  localparam int RANGE_B2_KHZ  = 1150;
  localparam int RANGE_B3_KHZ  = 1650;
  localparam int R10_AT_B1     = FREQ_PROGRAM_PIN_NUM_R10 / RANGE_B1_KHZ - FREQ_PROGRAM_PIN_OFS_R10;
  localparam int R10_AT_B2     = FREQ_PROGRAM_PIN_NUM_R10 / RANGE_B2_KHZ - FREQ_PROGRAM_PIN_OFS_R10;
  localparam int R10_AT_B3     = FREQ_PROGRAM_PIN_NUM_R10 / RANGE_B3_KHZ - FREQ_PROGRAM_PIN_OFS_R10;

  // Least times round up to whole cycles
  function automatic int ns_to_cyc_up(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : ns_to_cyc_up

  localparam int TIME_W        = 5;
  localparam int MIN_OFF_R1_NS = 150;
  localparam int MIN_OFF_R2_NS = 60;
  localparam int MIN_OFF_R3_NS = 40;
  localparam int MIN_OFF_R4_NS = 40;
  localparam int BLANK_LO_NS   = 95;                       // Ranges one to three
  localparam int BLANK_HI_NS   = 70;                       // Range four
  localparam logic [TIME_W-1:0] MIN_OFF_R1_CYC = TIME_W'(ns_to_cyc_up(MIN_OFF_R1_NS));
  localparam logic [TIME_W-1:0] MIN_OFF_R2_CYC = TIME_W'(ns_to_cyc_up(MIN_OFF_R2_NS));
  localparam logic [TIME_W-1:0] MIN_OFF_R3_CYC = TIME_W'(ns_to_cyc_up(MIN_OFF_R3_NS));
  localparam logic [TIME_W-1:0] MIN_OFF_R4_CYC = TIME_W'(ns_to_cyc_up(MIN_OFF_R4_NS));
  localparam logic [TIME_W-1:0] BLANK_LO_CYC   = TIME_W'(ns_to_cyc_up(BLANK_LO_NS));
  localparam logic [TIME_W-1:0] BLANK_HI_CYC   = TIME_W'(ns_to_cyc_up(BLANK_HI_NS));

  // Switch current limit
  localparam int ILIM_W                    = 12;
  localparam logic [ILIM_W-1:0] ILIM_NORM_MA  = 12'hd16;   // 3350 mA
  localparam logic [ILIM_W-1:0] ILIM_RAISE_MA = 12'he74;   // 3700 mA
  localparam int CL_HOLD_MS                = 1600;
  localparam int CL_HOLD_CYC               = CL_HOLD_MS * CLK_PER_MS;

  // Spread spectrum: +-31/1024 of the period, triangle at 1 kHz
  localparam int DITH_HALF     = 31;
  localparam int DITH_SPAN     = 2 * DITH_HALF;
  localparam int DITH_SHIFT    = 10;
  localparam int DITH_W        = 6;
  localparam int MOD_KHZ       = 1;
  localparam int TRI_STEP_CYC  = CLK_PER_MS / MOD_KHZ / (2 * DITH_SPAN);

  // External clock detection window, longest time rounds down
  localparam int SYNC_WIN_NS   = 8000;
  localparam int SYNC_WIN_CYC  = SYNC_WIN_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SW_REST = 2'b00, SW_READY = 2'b01, SW_ON = 2'b11} bsc_sw_t;
  typedef enum logic [1:0] {CL_NORMAL = 2'b00, CL_RAISED = 2'b01, CL_COOL = 2'b11} bsc_cl_t;
endpackage : bsc_pkg

// *** hw/bsc_sync3.sv ***
// Three-stage pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
module bsc_sync3
(
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  output logic      o_level
);
  logic meta;
  logic mid;
  logic late;
  logic next_level;

  // Level follows once second and third stage match
  always_comb
  begin
    next_level = (mid == late) ? late : o_level;
  end

  // Stage registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      meta    <= 1'b0;
      mid     <= 1'b0;
      late    <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta    <= i_pin;
      mid     <= meta;
      late    <= mid;
      o_level <= next_level;
    end
  end
endmodule : bsc_sync3

// *** hw/bsc_tick.sv ***
// Clock divider giving a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ps
module bsc_tick #(
  parameter int unsigned DIV = 806
)
(
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_run,
  output logic      o_pulse
);
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_pulse;

  // Count and wrap, cleared while stopped
  always_comb
  begin
    next_cnt   = cnt + 1'b1;
    next_pulse = 1'b0;
    if (!i_run)
      next_cnt = '0;
    else if (cnt == CW'(DIV - 1))
    begin
      next_cnt   = '0;
      next_pulse = 1'b1;
    end
  end

  // Counter and pulse registers
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      cnt     <= '0;
      o_pulse <= 1'b0;
    end
    else
    begin
      cnt     <= next_cnt;
      o_pulse <= next_pulse;
    end
  end
endmodule : bsc_tick

// *** test/bsc_host_model.sv ***
// Host model that drives the enable pin and the sync pin as a level or a clock
`timescale 1ns/1ps
module bsc_host_model #(
  parameter int SYNC_HALF_NS = 250
)
(
  input  wire logic i_clock_on,
  input  wire logic i_level,
  input  wire logic i_enable,
  output logic      o_sync_pin,
  output logic      o_io_supply_enable_pin
);
  // Enable pin powers the inputs and enables the device
  assign o_io_supply_enable_pin = i_enable;
  // Clock near the programmed rate, otherwise a still level
  initial o_sync_pin = 1'b0;
  always
  begin
    #(SYNC_HALF_NS);
    if (i_clock_on)
      o_sync_pin = ~o_sync_pin;
    else
      o_sync_pin = i_level;
  end
endmodule : bsc_host_model

// *** test/test_bsc_ctrl.sv ***
// Self-checking bench for the boost sync, spread and current-limit control
`timescale 1ns/1ps
module test_bsc_ctrl;
  localparam int HOLD = 200;
  logic        clk_sys = 1'b0;
  logic        reset_n, clock_on, level, enable, sync_pin, en_pin, loop_trip;
  logic        gate, enabled, ext, dith, raised, trip;
  logic [11:0] r10, cur, ilim;
  logic [1:0]  rng;
  logic [4:0]  moff, blank;
  int          n_errors = 0;
  int          n_checks = 0;
  int          rl[$] = '{244, 345, 346, 523, 524, 1344, 1345, 2188};
  int          moff_tab[4] = '{15, 6, 4, 4};
  int          blank_tab[4] = '{10, 10, 10, 7};
  int          k;

  always #5 clk_sys = ~clk_sys;

  bsc_host_model i_host (.i_clock_on(clock_on), .i_level(level), .i_enable(enable),
                         .o_sync_pin(sync_pin), .o_io_supply_enable_pin(en_pin));

  bsc_ctrl #(.CL_HOLD_CYC(HOLD), .SYNC_WIN_CYC(800), .TRI_STEP_CYC(4)) i_dut (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_io_supply_enable_pin(en_pin),
    .i_sync_pin(sync_pin), .i_freq_program_resistor(r10), .i_switch_current_ma(cur),
    .i_loop_trip(loop_trip), .o_switch_gate(gate), .o_enabled(enabled), .o_ext_sync(ext),
    .o_dither_on(dith), .o_freq_range(rng), .o_min_off_cyc(moff), .o_blank_cyc(blank),
    .o_ilimit_ma(ilim), .o_ilimit_raised(raised), .o_cl_trip(trip));

  // Compares one result and counts it
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // Reference range from the resistor, boundaries at 480, 1150 and 1650 kHz
  function automatic int exp_range(input int r);
    if (480 * (r + 64) > 676000) return 0;
    if (1150 * (r + 64) > 676000) return 1;
    if (1650 * (r + 64) > 676000) return 2;
    return 3;
  endfunction : exp_range

  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Cuts a hang short
  initial
  begin
    #1000000;
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    reset_n = 1'b0; clock_on = 1'b0; level = 1'b0; enable = 1'b0; loop_trip = 1'b0;
    r10 = 12'h112; cur = 12'h000;
    void'($urandom(32'h4b39));
    repeat (6) @(posedge clk_sys);
    tick(1);
    reset_n = 1'b1;
    cmp(ilim, 12'hd16, "reset limit");
    cmp(12'(enabled), 12'h000, "reset enable");
    enable = 1'b1;
    tick(600);
    cmp(12'(enabled), 12'h001, "enabled");
    cmp(12'(dith), 12'h000, "dither low");
    level = 1'b1;
    tick(600);
    cmp(12'(dith), 12'h001, "dither high");
    repeat (4) rl.push_back($urandom_range(244, 2188));
    foreach (rl[i])
    begin
      r10 = 12'(rl[i]);
      cur = 12'($urandom_range(0, 3349));
      loop_trip = 1'($urandom);
      tick(8);
      k = exp_range(rl[i]);
      cmp(12'(rng), 12'(k), "range");
      cmp(12'(moff), 12'(moff_tab[k]), "min off");
      cmp(12'(blank), 12'(blank_tab[k]), "blank");
    end
    r10 = 12'h112; loop_trip = 1'b0; clock_on = 1'b1;
    tick(400);
    cmp(12'(ext), 12'h001, "ext mode");
    cmp(12'(dith), 12'h000, "ext dither");
    clock_on = 1'b0;
    tick(1000);
    cmp(12'(ext), 12'h000, "clock lost");
    cmp(12'(dith), 12'h001, "final level");
    level = 1'b0; cur = 12'hd15;
    tick(300);
    cmp(12'(raised), 12'h000, "below limit");
    cur = 12'hd16;
    k = 0;
    while (trip !== 1'b1 && k < 200)
    begin
      tick(1);
      k++;
    end
    cmp(12'(trip), 12'h001, "trip");
    cmp(12'(gate), 12'h000, "gate cut");
    cmp(ilim, 12'he74, "raised");
    cur = 12'hfa0;
    tick(HOLD - 20);
    cmp(ilim, 12'he74, "hold");
    tick(40);
    cmp(ilim, 12'hd16, "cool");
    tick(HOLD + 80);
    cmp(ilim, 12'he74, "raise again");
    enable = 1'b0;
    tick(10);
    cmp(ilim, 12'hd16, "disabled limit");
    cmp(12'(raised), 12'h000, "disabled raise");
    complete_run();
  end
endmodule : test_bsc_ctrl
